// ### dv/scs_clock_ctrl_sva.sv
// assertions for the clock select and wake block
`timescale 1ns/1ps
`default_nettype none
module scs_clock_ctrl_sva (
  // clock, reset, bus
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic [3:0] regAddr,
  input wire logic       regRdEn,
  input wire logic [7:0] regRdData,
  // events and status
  input wire logic       haltReq,
  input wire logic       lvDetectEnable,
  input wire logic       sysClkOut,
  input wire logic       subOscEnable,
  input wire logic       cpuRun,
  input wire logic       highOscReady,
  input wire logic       lowOscReady,
  input wire logic       powerDownFlagSet,
  input wire logic       watchdogExpiredClr
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic ranOnce_ff;
  always_ff @(posedge sys_clk) ranOnce_ff <= srst ? 1'b0 : (ranOnce_ff | cpuRun);
  property p_rsvd; $past(regRdEn) && $past(regAddr) == 4'h1 |-> regRdData[6:3] == 4'h0; endproperty
  property p_halt; cpuRun && haltReq |=> !cpuRun && powerDownFlagSet; endproperty
  property p_pair; powerDownFlagSet |-> watchdogExpiredClr && !cpuRun; endproperty
  property p_once; powerDownFlagSet |=> !powerDownFlagSet; endproperty
  property p_lvd; cpuRun && haltReq && lvDetectEnable |=> subOscEnable [*2]; endproperty
  property p_deep; !subOscEnable |-> !lowOscReady; endproperty
  property p_glitch; $changed(sysClkOut) |=> $stable(sysClkOut); endproperty
  property p_pwrup; $rose(cpuRun) && !ranOnce_ff |-> highOscReady; endproperty
  property p_wake; $rose(cpuRun) |-> highOscReady || lowOscReady; endproperty
  a_rsvd: assert property (p_rsvd) else $error("flag spare bits set");
  a_halt: assert property (p_halt) else $error("halt not taken");
  a_pair: assert property (p_pair) else $error("halt pulses apart");
  a_once: assert property (p_once) else $error("pulse too long");
  a_lvd: assert property (p_lvd) else $error("deep sleep with detect on");
  a_deep: assert property (p_deep) else $error("low ready in deep sleep");
  a_glitch: assert property (p_glitch) else $error("short clock phase");
  a_pwrup: assert property (p_pwrup) else $error("run before high ready");
  a_wake: assert property (p_wake) else $error("run with no ready clock");
  c_halt: cover property (cpuRun && haltReq);
  c_quick: cover property ($rose(cpuRun) && !highOscReady);
  c_flags: cover property (regRdEn && regAddr == 4'h1);
endmodule
bind scs_clock_ctrl scs_clock_ctrl_sva u_sva (.sys_clk(sys_clk), .srst(srst),
  .regAddr(regAddr), .regRdEn(regRdEn), .regRdData(regRdData), .haltReq(haltReq),
  .lvDetectEnable(lvDetectEnable), .sysClkOut(sysClkOut), .subOscEnable(subOscEnable),
  .cpuRun(cpuRun), .highOscReady(highOscReady), .lowOscReady(lowOscReady),
  .powerDownFlagSet(powerDownFlagSet), .watchdogExpiredClr(watchdogExpiredClr));
`default_nettype wire

// ### dv/scs_clock_ctrl_tb_top.sv
// self-checking bench for the clock select and wake block
`timescale 1ns/1ps
`default_nettype none
module scs_clock_ctrl_tb_top;
  import scs_pkg::*;
  logic       sys_clk, srst, regWrEn, regRdEn, fastOscClk, subOscClk, haltReq, wakeReq;
  logic       highIsCrystal, lowIsCrystal, watchdogEnable, lvDetectEnable, sysClkOut;
  logic       fastOscEnable, subOscEnable, cpuRun, highOscReady, lowOscReady;
  logic       powerDownFlagSet, watchdogExpiredClr, idle, keep, wdt, lvd, q, deep, prev;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData, rd, d;
  logic [4:0] hc [5] = '{5'b00001, 5'b00011, 5'b00100, 5'b10001, 5'b11000};
  int         n_fail, tests_run, cyc, seed, n, tg;
  scs_clock_ctrl DUT (.sys_clk(sys_clk), .srst(srst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .fastOscClk(fastOscClk), .subOscClk(subOscClk), .highIsCrystal(highIsCrystal),
    .lowIsCrystal(lowIsCrystal), .watchdogEnable(watchdogEnable),
    .lvDetectEnable(lvDetectEnable), .haltReq(haltReq), .wakeReq(wakeReq),
    .sysClkOut(sysClkOut), .fastOscEnable(fastOscEnable), .subOscEnable(subOscEnable),
    .cpuRun(cpuRun), .highOscReady(highOscReady), .lowOscReady(lowOscReady),
    .powerDownFlagSet(powerDownFlagSet), .watchdogExpiredClr(watchdogExpiredClr));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // fast osc 6 cycles, sub osc 20 cycles, phase apart from sys_clk
  initial begin
    fastOscClk = 1'b0;
    #3;
    forever #24 fastOscClk = ~fastOscClk;
  end
  initial begin
    subOscClk = 1'b0;
    #5;
    forever #80 subOscClk = ~subOscClk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= v;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1 rd = regRdData;
  endtask
  // one sysClkOut period in sys_clk cycles, after settling
  task automatic per();
    repeat (2) begin
      do begin @(posedge sys_clk); #1; end while (sysClkOut !== 1'b0);
      do begin @(posedge sys_clk); #1; end while (sysClkOut !== 1'b1);
    end
    n = 0;
    do begin @(posedge sys_clk); #1; n++; end while (sysClkOut === 1'b1);
    do begin @(posedge sys_clk); #1; n++; end while (sysClkOut === 1'b0);
  endtask
  task automatic pulse_in(input bit h);
    @(posedge sys_clk);
    if (h) haltReq <= 1'b1; else wakeReq <= 1'b1;
    @(posedge sys_clk);
    haltReq <= 1'b0;
    wakeReq <= 1'b0;
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      stop_test;
    end
  end
  initial begin
    seed = 32'he618;
    {srst, regAddr, regWrData, regWrEn, regRdEn, haltReq, wakeReq} = {1'b1, 16'h0000};
    {highIsCrystal, lowIsCrystal, watchdogEnable, lvDetectEnable} = 4'h8;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    while (cpuRun !== 1'b1) begin @(posedge sys_clk); #1; end
    rdr(ADDR_MODE_CTRL); chk(rd, 8'h0f, "mode at start");
    rdr(ADDR_CLK_FLAGS); chk(rd, 8'h00, "flags at start");
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      wr(ADDR_CLK_FLAGS, d); rdr(ADDR_CLK_FLAGS); chk(rd, d & 8'h87, "flags");
      wr(ADDR_MODE_CTRL, d | 8'h01); rdr(ADDR_MODE_CTRL);
      chk(rd, d & 8'hf3 | 8'h0d, "mode");
    end
    rdr(4'h9); chk(rd, 8'h00, "unmapped");
    $display("test registers done");
    wr(ADDR_MODE_CTRL, 8'h03); per(); chk(n, 16'd6, "full clock");
    for (int c = 7; c >= 0; c--) begin
      wr(ADDR_MODE_CTRL, {c[2:0], 5'h02}); per();
      chk(n, (c < 2) ? 16'd20 : 16'd6 << (8 - c), "divided clock");
    end
    chk(fastOscEnable, 1'b0, "fast osc on sub");
    wr(ADDR_MODE_CTRL, 8'h03);
    while (highOscReady !== 1'b1) begin @(posedge sys_clk); #1; end
    per(); chk(n, 16'd6, "back to full");
    $display("test dividers done");
    for (int k = 0; k < 5; k++) begin
      {idle, keep, wdt, lvd, q} = hc[k];
      deep = !idle && !wdt && !lvd;
      watchdogEnable <= wdt;
      lvDetectEnable <= lvd;
      wr(ADDR_CLK_FLAGS, {keep, 7'h00});
      wr(ADDR_MODE_CTRL, {3'h0, q, 2'h0, idle, 1'b1});
      pulse_in(1'b1);
      #1 chk(cpuRun, 1'b0, "halt");
      chk(powerDownFlagSet & watchdogExpiredClr, 1'b1, "halt pulses");
      tg = 0;
      // let the gate close before counting toggles
      repeat (8) @(posedge sys_clk);
      #1 prev = sysClkOut;
      repeat (60) begin @(posedge sys_clk); #1 tg += (sysClkOut !== prev); prev = sysClkOut; end
      chk(tg > 0, idle && keep, "clock in halt");
      chk(subOscEnable, !deep, "sub osc in halt");
      chk(highOscReady, idle && keep, "high ready in halt");
      pulse_in(1'b0);
      while (cpuRun !== 1'b1) begin @(posedge sys_clk); #1; end
      chk(highOscReady, !(q && !deep && !keep), "ready at wake");
      while (highOscReady !== 1'b1) begin @(posedge sys_clk); #1; end
    end
    $display("test halt and wake done");
    stop_test;
  end
endmodule
`default_nettype wire

// ### src/scs_clock_ctrl.sv
// system clock selection, halt modes and wake-up sequencing
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module scs_clock_ctrl
  import scs_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // register port
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  // oscillator levels and configuration
  input  wire logic       fastOscClk,
  input  wire logic       subOscClk,
  input  wire logic       highIsCrystal,
  input  wire logic       lowIsCrystal,
  input  wire logic       watchdogEnable,
  input  wire logic       lvDetectEnable,
  // cpu events
  input  wire logic       haltReq,
  input  wire logic       wakeReq,
  // clock and status outputs
  output logic            sysClkOut,
  output logic            fastOscEnable,
  output logic            subOscEnable,
  output logic            cpuRun,
  output logic            highOscReady,
  output logic            lowOscReady,
  output logic            powerDownFlagSet,
  output logic            watchdogExpiredClr
);

  typedef struct packed {
    scs_state_t  state;
    logic [2:0]  divSel;
    logic        quickWake;
    logic        idleOnHalt;
    logic        highSel;
    logic        keepClk;
    logic [2:0]  rstFlags;
    logic [10:0] hiCnt;
    logic [10:0] loCnt;
    logic        hiRdy;
    logic        loRdy;
    logic [1:0]  wakeCnt;
    logic        wakeOnSub;
    logic        wakeShort;
    logic        fastPrev;
    logic        subPrev;
    logic [5:0]  divCnt;
    logic [3:0]  curSel;
    logic        gate;
    logic        sysClk;
    logic        fastEn;
    logic        subEn;
    logic [7:0]  rdData;
    logic        pdfSet;
    logic        toClr;
  } scs_regs_t;

  scs_regs_t st_ff;
  scs_regs_t nxt_st;

  logic        fastRise;
  logic        subRise;
  logic        fastWanted;
  logic [3:0]  wantSel;
  logic [10:0] hiTarget;
  logic [10:0] loTarget;
  logic        gateWant;
  logic        wakeTick;
  logic        wakeDone;

  ////////////////////////////////////////////////////////////////////////////
  // level of a candidate clock source
  function automatic logic srcLevel(input logic [3:0] sel, input logic [5:0] div,
                                    input logic fastLvl, input logic subLvl);
    logic [2:0] bitIdx;
    bitIdx = 3'h0;
    if (sel == SEL_FULL) begin
      srcLevel = fastLvl;
    end else if (sel[2:0] < DIV_FAST_MIN) begin
      srcLevel = subLvl;
    end else begin
      bitIdx   = DIV_TOP_CODE - sel[2:0];
      srcLevel = div[bitIdx];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.pdfSet = 1'b0;
    nxt_st.toClr  = 1'b0;
    nxt_st.rdData = 8'h00;

    fastRise        = fastOscClk & ~st_ff.fastPrev;
    subRise         = subOscClk & ~st_ff.subPrev;
    nxt_st.fastPrev = fastOscClk;
    nxt_st.subPrev  = subOscClk;

    fastWanted = st_ff.highSel | (st_ff.divSel >= DIV_FAST_MIN);
    hiTarget   = highIsCrystal ? CNT_HI_XTAL : CNT_HI_RC;
    loTarget   = lowIsCrystal ? CNT_LO_XTAL : CNT_LO_RC;

    // register writes
    if (regWrEn && regAddr == ADDR_MODE_CTRL) begin
      nxt_st.divSel     = regWrData[MODE_DIV_HI:MODE_DIV_LO];
      nxt_st.quickWake  = regWrData[MODE_QWAKE];
      nxt_st.idleOnHalt = regWrData[MODE_IDLE_HALT];
      nxt_st.highSel    = regWrData[MODE_HI_SEL];
    end
    if (regWrEn && regAddr == ADDR_CLK_FLAGS) begin
      nxt_st.keepClk  = regWrData[FLAG_KEEP_CLK];
      nxt_st.rstFlags = regWrData[FLAG_RST_HI:0];
    end

    // register reads, data one cycle later
    if (regRdEn && regAddr == ADDR_MODE_CTRL) begin
      nxt_st.rdData = {st_ff.divSel, st_ff.quickWake, st_ff.loRdy, st_ff.hiRdy,
                       st_ff.idleOnHalt, st_ff.highSel};
    end else if (regRdEn && regAddr == ADDR_CLK_FLAGS) begin
      nxt_st.rdData = {st_ff.keepClk, 4'h0, st_ff.rstFlags};
    end

    // operating state
    wakeTick = (st_ff.wakeOnSub || !fastWanted) ? subRise : fastRise;
    wakeDone = 1'b0;
    case (st_ff.state)
      ST_PWRUP: begin
        if (st_ff.hiRdy) begin
          nxt_st.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (haltReq) begin
          nxt_st.pdfSet = 1'b1;
          nxt_st.toClr  = 1'b1;
          if (st_ff.idleOnHalt) begin
            nxt_st.state = st_ff.keepClk ? ST_IDL1 : ST_IDL0;
          end else if (lvDetectEnable || watchdogEnable) begin
            nxt_st.state = ST_SLP1;
          end else begin
            nxt_st.state = ST_DEEP;
          end
        end
      end
      ST_IDL1: begin
        if (wakeReq) begin
          nxt_st.state     = ST_WAKE;
          nxt_st.wakeCnt   = 2'h0;
          nxt_st.wakeShort = 1'b1;
          nxt_st.wakeOnSub = 1'b0;
        end
      end
      ST_DEEP, ST_SLP1, ST_IDL0: begin
        if (wakeReq) begin
          nxt_st.state     = ST_WAKE;
          nxt_st.wakeCnt   = 2'h0;
          nxt_st.wakeShort = 1'b0;
          nxt_st.wakeOnSub = fastWanted && highIsCrystal && st_ff.quickWake &&
                             st_ff.state != ST_DEEP && st_ff.subEn;
        end
      end
      ST_WAKE: begin
        if (wakeTick && st_ff.wakeCnt != CNT_WAKE_SHORT) begin
          nxt_st.wakeCnt = st_ff.wakeCnt + 2'h1;
        end
        if (st_ff.wakeShort || st_ff.wakeOnSub) begin
          wakeDone = st_ff.wakeCnt == CNT_WAKE_SHORT;
        end else if (fastWanted) begin
          wakeDone = st_ff.hiRdy;
        end else begin
          wakeDone = st_ff.loRdy;
        end
        if (wakeDone) begin
          nxt_st.state = ST_RUN;
        end
      end
      default: begin
        nxt_st.state = ST_RUN;
      end
    endcase

    // oscillator enables
    nxt_st.fastEn = (st_ff.state == ST_PWRUP) ||
                    (fastWanted && (st_ff.state == ST_RUN || st_ff.state == ST_IDL1 ||
                                    st_ff.state == ST_WAKE));
    nxt_st.subEn  = st_ff.state != ST_DEEP;

    // stabilisation counters
    if (!st_ff.fastEn) begin
      nxt_st.hiCnt = 11'h000;
    end else if (fastRise && st_ff.hiCnt < hiTarget) begin
      nxt_st.hiCnt = st_ff.hiCnt + 11'h001;
    end
    if (!st_ff.subEn) begin
      nxt_st.loCnt = 11'h000;
    end else if (subRise && st_ff.loCnt < loTarget) begin
      nxt_st.loCnt = st_ff.loCnt + 11'h001;
    end
    nxt_st.hiRdy = nxt_st.fastEn && (nxt_st.hiCnt >= hiTarget);
    nxt_st.loRdy = nxt_st.subEn && (nxt_st.loCnt >= loTarget);

    // fast clock divider chain
    if (fastRise) begin
      nxt_st.divCnt = st_ff.divCnt + 6'h01;
    end

    // glitch-free source mux: switch only while both levels are low
    wantSel  = !(fastWanted && st_ff.hiRdy) ? SEL_SUB :
               (st_ff.highSel ? SEL_FULL : {1'b0, st_ff.divSel});
    gateWant = st_ff.state == ST_RUN || st_ff.state == ST_IDL1;
    if (!st_ff.sysClk &&
        !srcLevel(wantSel, st_ff.divCnt, fastOscClk, subOscClk)) begin
      nxt_st.curSel = wantSel;
    end
    // open the gate only while the selected source is low, so no short high phase
    if (!st_ff.sysClk &&
        (!gateWant || !srcLevel(nxt_st.curSel, nxt_st.divCnt, fastOscClk, subOscClk))) begin
      nxt_st.gate = gateWant;
    end
    nxt_st.sysClk = nxt_st.gate &&
                    srcLevel(nxt_st.curSel, nxt_st.divCnt, fastOscClk, subOscClk);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_ff            <= '0;
      st_ff.state      <= ST_PWRUP;
      st_ff.divSel     <= RST_DIV_SEL;
      st_ff.quickWake  <= RST_QWAKE;
      st_ff.idleOnHalt <= RST_IDLE_HALT;
      st_ff.highSel    <= RST_HI_SEL;
      st_ff.keepClk    <= RST_KEEP_CLK;
      st_ff.rstFlags   <= RST_RST_FLAGS;
      st_ff.curSel     <= SEL_FULL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign regRdData          = st_ff.rdData;
  assign sysClkOut          = st_ff.sysClk;
  assign fastOscEnable      = st_ff.fastEn;
  assign subOscEnable       = st_ff.subEn;
  assign cpuRun             = st_ff.state == ST_RUN;
  assign highOscReady       = st_ff.hiRdy;
  assign lowOscReady        = st_ff.loRdy;
  assign powerDownFlagSet   = st_ff.pdfSet;
  assign watchdogExpiredClr = st_ff.toClr;

endmodule

`default_nettype wire

// ### src/scs_pkg.sv
// shared constants and types for the system clock select and wake block
package scs_pkg;

  // register map
  localparam logic [3:0] ADDR_MODE_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_CLK_FLAGS  = 4'h1;

  // mode control field positions
  localparam int unsigned MODE_DIV_HI    = 7;
  localparam int unsigned MODE_DIV_LO    = 5;
  localparam int unsigned MODE_QWAKE     = 4;
  localparam int unsigned MODE_LO_READY  = 3;
  localparam int unsigned MODE_HI_READY  = 2;
  localparam int unsigned MODE_IDLE_HALT = 1;
  localparam int unsigned MODE_HI_SEL    = 0;

  // clock flags field positions
  localparam int unsigned FLAG_KEEP_CLK  = 7;
  localparam int unsigned FLAG_RST_HI    = 2;

  // reset values
  localparam logic [2:0] RST_DIV_SEL     = 3'h0;
  localparam logic       RST_QWAKE       = 1'b0;
  localparam logic       RST_IDLE_HALT   = 1'b1;
  localparam logic       RST_HI_SEL      = 1'b1;
  localparam logic       RST_KEEP_CLK    = 1'b0;
  localparam logic [2:0] RST_RST_FLAGS   = 3'h0;

  // divider select codes
  localparam logic [2:0] DIV_FAST_MIN    = 3'h2;
  localparam logic [2:0] DIV_TOP_CODE    = 3'h7;
  localparam logic [3:0] SEL_SUB         = 4'h0;
  localparam logic [3:0] SEL_FULL        = 4'h8;

  // stabilisation counts in oscillator cycles
  localparam logic [10:0] CNT_HI_XTAL    = 11'h400;
  localparam logic [10:0] CNT_HI_RC      = 11'h010;
  localparam logic [10:0] CNT_LO_XTAL    = 11'h400;
  localparam logic [10:0] CNT_LO_RC      = 11'h002;
  localparam logic [1:0]  CNT_WAKE_SHORT = 2'h2;

  // operating states
  typedef enum logic [7:0] {
    ST_PWRUP = 8'h01,
    ST_RUN   = 8'h02,
    ST_DEEP  = 8'h04,
    ST_SLP1  = 8'h08,
    ST_IDL0  = 8'h10,
    ST_IDL1  = 8'h20,
    ST_WAKE  = 8'h40,
    ST_SPARE = 8'h80
  } scs_state_t;

endpackage
